// [logic/amrm_pkg.sv]
/*
  amrm_pkg: register map, field positions, reset values and carrier types
  for the converter run control and result monitor block.
  Assumes a 32-bit APB with byte addresses; one aligned word per register.
*/
package amrm_pkg;
  localparam logic [7:0] OFF_RUN_CTRL = 8'h00;
  localparam logic [7:0] OFF_BUSY_STAT = 8'h04;
  localparam logic [7:0] OFF_SW_START = 8'h08;
  localparam logic [7:0] OFF_FIXED_MODE = 8'h0c;
  localparam logic [7:0] OFF_MON0_CTRL = 8'h10;
  localparam logic [7:0] OFF_MON0_CMP = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;

  localparam int RUN_ENABLE_BIT = 7;
  localparam int RUN_REPEAT_BIT = 0;
  localparam int BUSY_SW_BIT = 1;
  localparam int BUSY_ANY_BIT = 0;
  localparam int SW_START_BIT = 0;
  localparam int MON_CNT_LSB = 8;
  localparam int MON_EN_BIT = 7;
  localparam int MON_DIR_BIT = 4;
  localparam int MON_SEL_LSB = 0;
  localparam int CMP_LSB = 4;
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;

  localparam logic [31:0] FIXED_MODE_MASK = 32'h0000_ffff;
  localparam logic [31:0] FIXED_MODE_RESET = 32'h0000_0458;
  localparam logic [31:0] RUN_CTRL_MASK = 32'h0000_0081;
  localparam logic [31:0] MON_CTRL_MASK = 32'h0000_0f9f;
  localparam logic [31:0] MON_CMP_MASK = 32'h0000_fff0;
  localparam logic [1:0] IRQ_BITS_MASK = 2'h3;

  localparam int RESULT_W = 12;
  localparam int RESULT_REGS = 12;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_BUSY,
    CONV_BUSY_SW
  } amrm_conv_state_type;

  // events reported by the conversion core, each a one-cycle pulse
  typedef struct packed {
    logic start;
    logic start_sw;
    logic done;
    logic res_wr;
    logic [3:0] res_idx;
    logic [RESULT_W-1:0] res_data;
  } amrm_conv_event_type;

  typedef struct packed {
    logic [3:0] cnt_thresh;
    logic enable;
    logic dir_le;
    logic [3:0] sel;
  } amrm_mon_cfg_type;
endpackage

// [logic/amrm_top.sv]
/*
  amrm_top: converter run control, busy tracking, fixed analog mode
  register and result monitor 0, reached over an APB slave.
  Assumes the conversion core reports start, done and result writes as
  one-cycle pulses on sys_clk, and takes enable and repeat levels and a one-cycle start pulse.
*/
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module amrm_top #(
  parameter int RESULT_REGS = 12,
  parameter int RESULT_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire amrm_pkg::amrm_conv_event_type conv_evt,
  output logic conv_enable,
  output logic repeat_enable,
  output logic sw_start,
  output logic monitor_match_irq,
  output logic irq
);
  // the monitor decode and compare width are fixed by the package
  generate
    if (RESULT_REGS != amrm_pkg::RESULT_REGS || RESULT_W != amrm_pkg::RESULT_W) begin : g_chk
      $error("amrm_top: only 12 result registers of 12 bits are served");
    end
  endgenerate

  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      amrm_pkg::OFF_RUN_CTRL, amrm_pkg::OFF_BUSY_STAT, amrm_pkg::OFF_SW_START,
      amrm_pkg::OFF_FIXED_MODE, amrm_pkg::OFF_MON0_CTRL, amrm_pkg::OFF_MON0_CMP,
      amrm_pkg::OFF_IRQ_STAT, amrm_pkg::OFF_IRQ_MASK: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // bus slave state
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;

  // software registers
  logic [31:0] run_q;
  logic [31:0] run_d;
  logic repeat_q;
  logic repeat_d;
  logic [31:0] mode_q;
  logic [31:0] mode_d;
  logic [31:0] mon_ctrl_q;
  logic [31:0] mon_ctrl_d;
  logic [31:0] mon_cmp_q;
  logic [31:0] mon_cmp_d;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_stat_d;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_mask_d;
  logic irq_q;
  logic irq_d;
  logic sw_start_q;
  logic sw_start_d;

  // conversion tracking and monitor
  amrm_pkg::amrm_conv_state_type conv_q;
  amrm_pkg::amrm_conv_state_type conv_d;
  logic [3:0] match_cnt_q;
  logic [3:0] match_cnt_d;
  logic match_irq_q;
  logic match_irq_d;

  logic setup;
  logic access_done;
  logic wr_en;
  logic rd_clear;
  logic busy_any;
  logic busy_sw;
  logic mon_fire;
  amrm_pkg::amrm_mon_cfg_type mon_cfg;

  assign setup = psel && !penable;
  assign access_done = psel && penable && pready_q;
  // unmapped writes were flagged at setup and are dropped at the commit edge
  assign wr_en = access_done && pwrite && !pslverr_q;
  // status clears only at the commit edge of a status read
  assign rd_clear = access_done && !pwrite && paddr == amrm_pkg::OFF_IRQ_STAT;
  assign busy_any = conv_q != amrm_pkg::CONV_IDLE;
  assign busy_sw = conv_q == amrm_pkg::CONV_BUSY_SW;

  // unpack the control word; bits 6:5 read as zero and have no field
  always_comb begin
    mon_cfg.cnt_thresh = mon_ctrl_q[amrm_pkg::MON_CNT_LSB +: 4];
    mon_cfg.enable = mon_ctrl_q[amrm_pkg::MON_EN_BIT];
    mon_cfg.dir_le = mon_ctrl_q[amrm_pkg::MON_DIR_BIT];
    mon_cfg.sel = mon_ctrl_q[amrm_pkg::MON_SEL_LSB +: 4];
  end

  // apb: answer in the cycle after setup, so every access has zero wait
  always_comb begin
    pready_d = setup;
    pslverr_d = setup ? !addr_mapped(paddr) : 1'b0;
    prdata_d = prdata_q;
    if (setup && !pwrite) begin
      case (paddr)
        amrm_pkg::OFF_RUN_CTRL: prdata_d = run_q;
        amrm_pkg::OFF_BUSY_STAT: begin
          prdata_d = 32'h0000_0000;
          prdata_d[amrm_pkg::BUSY_SW_BIT] = busy_sw;
          prdata_d[amrm_pkg::BUSY_ANY_BIT] = busy_any;
        end
        amrm_pkg::OFF_FIXED_MODE: prdata_d = mode_q;
        amrm_pkg::OFF_MON0_CTRL: prdata_d = mon_ctrl_q;
        amrm_pkg::OFF_MON0_CMP: prdata_d = mon_cmp_q;
        amrm_pkg::OFF_IRQ_STAT: prdata_d = {30'h0, irq_stat_q};
        amrm_pkg::OFF_IRQ_MASK: prdata_d = {30'h0, irq_mask_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // software registers; masks keep reserved bits at zero
  always_comb begin
    run_d = run_q;
    mode_d = mode_q;
    mon_ctrl_d = mon_ctrl_q;
    mon_cmp_d = mon_cmp_q;
    irq_mask_d = irq_mask_q;
    sw_start_d = 1'b0;
    if (wr_en) begin
      case (paddr)
        amrm_pkg::OFF_RUN_CTRL: run_d = pwdata & amrm_pkg::RUN_CTRL_MASK;
        // held as written; software keeps the fixed value
        amrm_pkg::OFF_FIXED_MODE: mode_d = pwdata & amrm_pkg::FIXED_MODE_MASK;
        amrm_pkg::OFF_MON0_CTRL: mon_ctrl_d = pwdata & amrm_pkg::MON_CTRL_MASK;
        amrm_pkg::OFF_MON0_CMP: mon_cmp_d = pwdata & amrm_pkg::MON_CMP_MASK;
        amrm_pkg::OFF_IRQ_MASK: irq_mask_d = pwdata[1:0] & amrm_pkg::IRQ_BITS_MASK;
        // start only while enabled: a disabled converter ignores it
        amrm_pkg::OFF_SW_START: sw_start_d = pwdata[amrm_pkg::SW_START_BIT]
          && run_q[amrm_pkg::RUN_ENABLE_BIT];
        default: run_d = run_q;
      endcase
    end
    // registered so the pin cannot glitch while the control word settles
    repeat_d = run_d[amrm_pkg::RUN_REPEAT_BIT] && run_d[amrm_pkg::RUN_ENABLE_BIT];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 32'h0000_0000;
      repeat_q <= 1'b0;
      mode_q <= amrm_pkg::FIXED_MODE_RESET;
      mon_ctrl_q <= 32'h0000_0000;
      mon_cmp_q <= 32'h0000_0000;
      irq_mask_q <= 2'h0;
      sw_start_q <= 1'b0;
    end else begin
      run_q <= run_d;
      repeat_q <= repeat_d;
      mode_q <= mode_d;
      mon_ctrl_q <= mon_ctrl_d;
      mon_cmp_q <= mon_cmp_d;
      irq_mask_q <= irq_mask_d;
      sw_start_q <= sw_start_d;
    end
  end

  // busy tracking; a start in the done cycle keeps the flag up
  always_comb begin
    conv_d = conv_q;
    case (conv_q)
      amrm_pkg::CONV_IDLE: begin
        if (conv_evt.start) begin
          conv_d = conv_evt.start_sw ? amrm_pkg::CONV_BUSY_SW : amrm_pkg::CONV_BUSY;
        end
      end
      amrm_pkg::CONV_BUSY, amrm_pkg::CONV_BUSY_SW: begin
        if (conv_evt.start) begin
          conv_d = conv_evt.start_sw ? amrm_pkg::CONV_BUSY_SW : amrm_pkg::CONV_BUSY;
        end else if (conv_evt.done) begin
          conv_d = amrm_pkg::CONV_IDLE;
        end
      end
      // the spare state code falls back to idle
      default: conv_d = amrm_pkg::CONV_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_q <= amrm_pkg::CONV_IDLE;
    end else begin
      conv_q <= conv_d;
    end
  end

  // monitor 0: consecutive matches on the selected result
  logic sel_hit;
  logic is_match;
  logic [RESULT_W-1:0] cmp_val;
  assign cmp_val = mon_cmp_q[amrm_pkg::CMP_LSB +: RESULT_W];
  // selections 12 to 15 name no result register and never compare
  assign sel_hit = conv_evt.res_wr && mon_cfg.sel == conv_evt.res_idx
    && mon_cfg.sel < 4'(RESULT_REGS);
  assign is_match = mon_cfg.dir_le ? (conv_evt.res_data <= cmp_val)
    : (conv_evt.res_data >= cmp_val);
  assign mon_fire = mon_cfg.enable && sel_hit && is_match
    && match_cnt_q == mon_cfg.cnt_thresh;

  always_comb begin
    match_cnt_d = match_cnt_q;
    match_irq_d = mon_fire;
    if (!mon_cfg.enable) begin
      match_cnt_d = 4'h0;
    end else if (sel_hit) begin
      if (!is_match || mon_fire) begin
        match_cnt_d = 4'h0;
      end else begin
        match_cnt_d = match_cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_cnt_q <= 4'h0;
      match_irq_q <= 1'b0;
    end else begin
      match_cnt_q <= match_cnt_d;
      match_irq_q <= match_irq_d;
    end
  end

  // sticky status, cleared by read; only bits seen by the read are cleared,
  // and a new event in the clearing cycle still sets its bit
  logic [1:0] irq_evt;
  always_comb begin
    irq_evt = 2'h0;
    irq_evt[amrm_pkg::IRQ_MATCH_BIT] = mon_fire;
    irq_evt[amrm_pkg::IRQ_DONE_BIT] = conv_evt.done && busy_any;
    irq_stat_d = irq_stat_q;
    if (rd_clear) begin
      irq_stat_d = irq_stat_q & ~prdata_q[1:0];
    end
    irq_stat_d = irq_stat_d | irq_evt;
    // mask meets the next status, so irq follows the flag with no extra cycle
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign conv_enable = run_q[amrm_pkg::RUN_ENABLE_BIT];
  assign repeat_enable = repeat_q;
  assign sw_start = sw_start_q;
  assign monitor_match_irq = match_irq_q;
  assign irq = irq_q;
endmodule

// [testbench/amrm_checker.sv]
/*
  amrm_checker: port-level properties of amrm_top.
  Assumes one clock domain and rst_n active low; bound below.
*/
`timescale 1ns/1ps
module amrm_checker #(
  parameter int RESULT_REGS = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire amrm_pkg::amrm_conv_event_type conv_evt,
  input wire logic conv_enable,
  input wire logic repeat_enable,
  input wire logic sw_start,
  input wire logic monitor_match_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic rd_ok;
  assign rd_ok = pready && !pwrite;
  property p_rep; repeat_enable |-> conv_enable; endproperty
  a_rep: assert property (p_rep) else $error("repeat while off");
  property p_sw_en; sw_start |-> $past(conv_enable); endproperty
  a_sw_en: assert property (p_sw_en) else $error("start while off");
  property p_en_hold;
    !(psel && penable && pwrite && paddr == amrm_pkg::OFF_RUN_CTRL) |=> $stable(conv_enable);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable moved");
  property p_sw_pulse; sw_start |=> !sw_start; endproperty
  a_sw_pulse: assert property (p_sw_pulse) else $error("start too long");
  property p_mcause; monitor_match_irq |-> $past(conv_evt.res_wr); endproperty
  a_mcause: assert property (p_mcause) else $error("match without result");
  property p_msel; monitor_match_irq |-> $past(conv_evt.res_idx) < RESULT_REGS; endproperty
  a_msel: assert property (p_msel) else $error("bad select");
  property p_run_rsv; rd_ok && paddr == 8'h00 |-> (prdata & 32'hffff_ff7e) == 0; endproperty
  a_run_rsv: assert property (p_run_rsv) else $error("run reserved set");
  property p_busy_rsv; rd_ok && paddr == 8'h04 |-> prdata[31:2] == 0; endproperty
  a_busy_rsv: assert property (p_busy_rsv) else $error("busy reserved set");
  property p_mon_rsv; rd_ok && paddr == 8'h10 |-> (prdata & 32'hffff_f060) == 0; endproperty
  a_mon_rsv: assert property (p_mon_rsv) else $error("monitor reserved set");
  c_match: cover property (monitor_match_irq);
  c_rep: cover property (repeat_enable);
  c_sw: cover property (sw_start);
endmodule

bind amrm_top amrm_checker #(.RESULT_REGS(RESULT_REGS)) amrm_checker_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .conv_evt(conv_evt),
  .conv_enable(conv_enable), .repeat_enable(repeat_enable), .sw_start(sw_start),
  .monitor_match_irq(monitor_match_irq));

// [testbench/amrm_core_model.sv]
/*
  amrm_core_model: behavioural conversion core with trigger inputs.
  Assumes amrm_pkg compiled first; lat of at least 1 cycle.
*/
`timescale 1ns/1ps
module amrm_core_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic conv_enable,
  input wire logic repeat_enable,
  input wire logic sw_start,
  input wire logic hw_trig,
  input wire logic [4:0] lat,
  input wire logic [3:0] idx,
  input wire logic [11:0] data,
  output amrm_pkg::amrm_conv_event_type conv_evt
);
  int cnt;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      conv_evt <= '0;
    end else begin
      // unqualified result lines carry inverted data, never a stale value
      if (cnt == 0 && conv_enable && (sw_start || hw_trig || repeat_enable)) begin
        conv_evt <= {1'b1, sw_start, 2'h0, ~idx, ~data};
        cnt <= int'(lat);
      end else if (cnt == 1) begin
        conv_evt <= {4'h3, idx, data};
        cnt <= 0;
      end else begin
        conv_evt <= {4'h0, ~idx, ~data};
        if (cnt > 1) cnt <= cnt - 1;
      end
    end
  end
endmodule

// [testbench/amrm_top_tb.sv]
/*
  amrm_top_tb: self-checking bench for amrm_top with a monitor model.
  Assumes amrm_pkg, amrm_top, the core model and the checker compiled first.
*/
`timescale 1ns/1ps
module amrm_top_tb;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, trig = 0, sl;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, d, mctl = '0, mcmp = '0;
  logic [3:0] idx = '0;
  logic [11:0] data = '0;
  logic [4:0] lat = 5'h10;
  logic pready, pslverr, cen, ren, swst, mirq, irq, exp_m = 0;
  amrm_pkg::amrm_conv_event_type evt;
  int fails = 0, cmp_count = 0, mcnt = 0, seed = 1158, nfire = 0;
  always #2 sys_clk = ~sys_clk;
  amrm_top amrm_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_evt(evt), .conv_enable(cen), .repeat_enable(ren),
    .sw_start(swst), .monitor_match_irq(mirq), .irq(irq));
  amrm_core_model amrm_core_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .conv_enable(cen),
    .repeat_enable(ren), .sw_start(swst), .hw_trig(trig), .lat(lat), .idx(idx),
    .data(data), .conv_evt(evt));
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no wait limit here: the watchdog ends a hung transfer
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a == 8'h10) mctl = v & amrm_pkg::MON_CTRL_MASK;
    if (w && a == 8'h14) mcmp = v;
    @(posedge sys_clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task wt;
    while (evt.done !== 1'b1) begin
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
  endtask
  task conv(input logic [3:0] i, input logic [11:0] v);
    idx <= i;
    data <= v;
    trig <= 1'b1;
    @(posedge sys_clk);
    trig <= 1'b0;
    wt();
  endtask
  // reference monitor: consecutive matches on the selected result
  always @(posedge sys_clk) begin
    if (rst_n) chk({31'h0, mirq}, {31'h0, exp_m});
    exp_m = 1'b0;
    if (!mctl[7]) mcnt = 0;
    else if (evt.res_wr && evt.res_idx == mctl[3:0] && mctl[3:0] < 4'hc) begin
      if (mctl[4] ? evt.res_data <= mcmp[15:4] : evt.res_data >= mcmp[15:4]) begin
        exp_m = (mcnt == int'(mctl[11:8]));
        mcnt = exp_m ? 0 : mcnt + 1;
        if (exp_m) nfire++;
      end else mcnt = 0;
    end
  end
  initial begin
    #100000;
    fails++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(8'h00, 32'h0);
    chk({31'h0, cen}, 32'h0);
    rd(8'h0c, amrm_pkg::FIXED_MODE_RESET);
    rd(8'h10, 32'h0);
    rd(8'h20, 32'h0);
    chk({31'h0, sl}, 32'h1);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0000_0f9f);
    apb(1'b1, 8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0000_fff0);
    apb(1'b1, 8'h0c, 32'h0000_0458);
    apb(1'b1, 8'h08, 32'h1);
    repeat (6) @(posedge sys_clk);
    rd(8'h04, 32'h0);
    apb(1'b1, 8'h1c, 32'h3);
    apb(1'b1, 8'h00, 32'h80);
    chk({31'h0, cen}, 32'h1);
    apb(1'b1, 8'h08, 32'h1);
    repeat (3) @(posedge sys_clk);
    rd(8'h04, 32'h3);
    wt();
    rd(8'h04, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd(8'h18, 32'h2);
    rd(8'h18, 32'h0);
    chk({31'h0, irq}, 32'h0);
    trig <= 1'b1;
    @(posedge sys_clk);
    trig <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(8'h04, 32'h1);
    wt();
    // the last pass selects code 13, which names no result register
    for (int c = 0; c < 7; c++) begin
      apb(1'b1, 8'h10, 32'h0);
      d = $random(seed);
      apb(1'b1, 8'h14, d);
      apb(1'b1, 8'h10, {20'h0, (c == 3 ? 4'hf : 4'(c)), 3'h4, c[0], 4'(c * 2 + 1)});
      repeat (48) begin
        d = $random(seed);
        lat <= 5'(1 + d[15:12]);
        conv(d[0] ? mctl[3:0] : 4'(d[7:4] % 12),
          (c == 3 || d[11:10] != 0) ? mcmp[15:4] : mcmp[15:4] ^ {10'h0, d[2:1]});
      end
    end
    apb(1'b1, 8'h10, 32'h0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h1c, 32'h0);
    rd(8'h18, (nfire != 0) ? 32'h3 : 32'h2);
    conv(4'h0, 12'h0);
    chk({31'h0, irq}, 32'h0);
    rd(8'h18, 32'h2);
    apb(1'b1, 8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h81);
    chk({31'h0, ren}, 32'h1);
    repeat (60) @(posedge sys_clk);
    apb(1'b1, 8'h00, 32'h80);
    chk({31'h0, ren}, 32'h0);
    repeat (40) @(posedge sys_clk);
    conclude();
  end
endmodule
